/* File: core/tss_switch.sv */
// tss_switch: 256 x 256 channel time-slot interchange with host port.
// assumes: mclk_in far faster than serial_clk_in; all pins asynchronous
// to mclk_in; three-state and open-drain pins resolved outside.
//
// Operation
// - take eight serial input lines of 32 channels at 2.048 Mbit/s
// - drive eight three-state serial output lines of 32 slots
// - any of 256 inputs reaches any of 256 outputs, no blocking
// - each output channel chooses variable or constant delay
// - constant delay keeps grouped channels in their frame alignment
// - reset low clears all counters and registers
// - reset low puts every serial output at high impedance
// - frame pulse polarity is found without software help
// - serial data move on a 4.096 MHz clock, twice the bit rate
// - six host address lines select the register or memory
// - access happens only with strobe high and chip select low
// - host sets direction; device drives data bus only on reads
// - acknowledge pulls low when a host transfer is complete
// - data bus reaches control register, both control halves, data
// - drive enable low forces all serial outputs to high impedance
// - drive enable high still lets one channel go high impedance
// - control serial output carries 256 bits per frame
// - each control bit comes from its connection high location
// - active-high pulse means one format, active-low the other
// - a 125 us frame holds 32 channels of eight bits
// - output from data memory, or connection low in message mode
// - frame pulse restarts the sequential data memory write counter
`timescale 1ns/10ps
`include "tss_cfg.svh"
module tss_switch #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic serial_clk_in,
    input wire logic frame_sync_in,
    input wire logic [7:0] serial_in_lines_in,
    input wire logic out_drive_en_in,
    input wire logic [5:0] host_addr_in,
    input wire logic host_strobe_in,
    input wire logic host_cs_n_in,
    input wire logic host_rw_in,
    input wire logic [7:0] host_data_in,
    output logic [7:0] serial_out_lines_out,
    output logic [7:0] serial_out_lines_oe_out,
    output logic ctrl_serial_out,
    output logic [7:0] host_data_out,
    output logic host_data_oe_out,
    output logic xfer_ack_n_out,
    output logic xfer_ack_n_oe_out
);
    localparam int FW = 17;

    tss_pkg::tss_st_t st_ff;
    tss_pkg::tss_st_t nxt_st;
    logic rise, fall, gci, bnd, smp, fp_act, acc, dm_rd;
    logic [8:0] cnt_n;
    logic [2:0] bp;
    logic [7:0] maddr;
    logic fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [FW-1:0] fifo_in_data, fifo_out_data;

    tss_mem_if #(.AW(9), .DW(8)) dm_bus ();
    tss_mem_if #(.AW(8), .DW(8)) cml_bus ();
    tss_mem_if #(.AW(8), .DW(8)) cmh_bus ();

    if (FIFO_DEPTH < 8 || `TSS_MCLK_KHZ < 8 * `TSS_SCLK_KHZ) begin : g_chk
        $error("tss_switch: fifo too shallow or mclk too slow");
    end

    // a changed pin level counts once the 2nd and 3rd stages agree
    function automatic logic [7:0] tss_agree(input logic [7:0] a,
        input logic [7:0] b, input logic [7:0] cur);
        return (a & b) | (cur & (a | b));
    endfunction : tss_agree

    // data memory, bank in the top address bit, and connection halves
    tss_ram #(.AW(9), .DW(8)) u_dm (.clk_in(mclk_in), .bus_if(dm_bus));
    tss_ram #(.AW(8), .DW(8)) u_cml (.clk_in(mclk_in), .bus_if(cml_bus));
    tss_ram #(.AW(8), .DW(8)) u_cmh (.clk_in(mclk_in), .bus_if(cmh_bus));

    // captured bytes queue here so host reads never lose input data
    assign fifo_in_data = {st_ff.hold_bank, st_ff.pidx, st_ff.hold_ch,
        st_ff.hold[st_ff.pidx]};
    tss_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(st_ff.push_act),
        .in_ready_out(fifo_in_ready),
        .in_data_in(fifo_in_data),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_pop),
        .out_data_out(fifo_out_data)
    );

    // serial clock edges and the format-dependent edge roles
    assign rise = st_ff.m2[`TSS_MS_SCK] && st_ff.m3[`TSS_MS_SCK]
        && !st_ff.mlv[`TSS_MS_SCK];
    assign fall = !st_ff.m2[`TSS_MS_SCK] && !st_ff.m3[`TSS_MS_SCK]
        && st_ff.mlv[`TSS_MS_SCK];
    assign gci = !st_ff.idle_lvl;
    assign bnd = gci ? rise : fall;
    assign smp = gci ? fall : rise;
    assign fp_act = st_ff.det && (st_ff.mlv[`TSS_MS_FS] != st_ff.idle_lvl);
    assign cnt_n = fp_act ? 9'h000 : st_ff.cnt + 9'h001;
    assign bp = cnt_n[3:1];
    assign acc = st_ff.mlv[`TSS_MS_DS] && !st_ff.mlv[`TSS_MS_CSN];
    assign maddr = {st_ff.ctrl[2:0], host_addr_in[4:0]};

    always_comb begin
        nxt_st = st_ff;
        dm_bus.addr = 9'h000;
        dm_bus.wdata = 8'h00;
        dm_bus.we = 1'b0;
        cml_bus.addr = 8'h00;
        cml_bus.wdata = host_data_in;
        cml_bus.we = 1'b0;
        cmh_bus.addr = 8'h00;
        cmh_bus.wdata = host_data_in;
        cmh_bus.we = 1'b0;
        dm_rd = 1'b0;
        fifo_pop = 1'b0;

        // pin synchronisers; first stage feeds only the second
        nxt_st.m1 = {3'h0, host_strobe_in, host_cs_n_in, out_drive_en_in,
            frame_sync_in, serial_clk_in};
        nxt_st.m2 = st_ff.m1;
        nxt_st.m3 = st_ff.m2;
        nxt_st.mlv = tss_agree(st_ff.m2, st_ff.m3, st_ff.mlv);
        nxt_st.i1 = serial_in_lines_in;
        nxt_st.i2 = st_ff.i1;
        nxt_st.i3 = st_ff.i2;
        nxt_st.ilv = tss_agree(st_ff.i2, st_ff.i3, st_ff.ilv);

        // polarity: the level seen for many clocks in a row is idle
        if (rise) begin
            if (st_ff.mlv[`TSS_MS_FS] == st_ff.fs_last) begin
                if (st_ff.run == `TSS_RUN_MIN) begin
                    nxt_st.idle_lvl = st_ff.mlv[`TSS_MS_FS];
                    nxt_st.det = 1'b1;
                end else begin
                    nxt_st.run = st_ff.run + 5'h01;
                end
            end else begin
                nxt_st.run = 5'h00;
            end
            nxt_st.fs_last = st_ff.mlv[`TSS_MS_FS];
        end

        // host transfer done and released: drop acknowledge and bus
        if (st_ff.ack && !acc) begin
            nxt_st.ack = 1'b0;
            nxt_st.hoe = 1'b0;
        end

        // one engine shares the memories between prefetch and host
        unique case (st_ff.seq)
            tss_pkg::sq_idle: begin
                if (st_ff.pf_req) begin
                    nxt_st.pf_req = 1'b0;
                    nxt_st.ps = 3'h0;
                    nxt_st.seq = tss_pkg::sq_cm;
                end else if (acc && !st_ff.ack) begin
                    nxt_st.hrd = host_rw_in;
                    if (!host_addr_in[`TSS_HA_MEM]) begin
                        if (host_rw_in) begin
                            nxt_st.hdo = st_ff.ctrl;
                            nxt_st.hoe = 1'b1;
                        end else begin
                            nxt_st.ctrl = host_data_in;
                        end
                        nxt_st.ack = 1'b1;
                    end else if (host_rw_in) begin
                        // host sees the last complete frame
                        dm_bus.addr = {!st_ff.bank, maddr};
                        dm_rd = 1'b1;
                        cml_bus.addr = maddr;
                        cmh_bus.addr = maddr;
                        nxt_st.seq = tss_pkg::sq_hrd;
                    end else begin
                        // data memory is read-only from the host side
                        cml_bus.addr = maddr;
                        cmh_bus.addr = maddr;
                        cml_bus.we = st_ff.ctrl[4:3] == `TSS_SEL_CML;
                        cmh_bus.we = st_ff.ctrl[4:3] == `TSS_SEL_CMH;
                        nxt_st.ack = 1'b1;
                    end
                end
            end
            tss_pkg::sq_hrd: begin
                unique case (st_ff.ctrl[4:3])
                    `TSS_SEL_DM: nxt_st.hdo = dm_bus.rdata;
                    `TSS_SEL_CML: nxt_st.hdo = cml_bus.rdata;
                    `TSS_SEL_CMH: nxt_st.hdo = cmh_bus.rdata;
                    default: nxt_st.hdo = 8'h00;
                endcase
                nxt_st.hoe = 1'b1;
                nxt_st.ack = 1'b1;
                nxt_st.seq = tss_pkg::sq_idle;
            end
            tss_pkg::sq_cm: begin
                cml_bus.addr = {st_ff.ps, st_ff.pch};
                cmh_bus.addr = {st_ff.ps, st_ff.pch};
                nxt_st.seq = tss_pkg::sq_dm;
            end
            tss_pkg::sq_dm: begin
                // constant: previous frame for all; variable: newest copy
                if (cmh_bus.rdata[`TSS_CMH_CONST]) begin
                    dm_bus.addr = {!st_ff.bank, cml_bus.rdata};
                end else if (cml_bus.rdata[4:0] < st_ff.cnt[8:4]) begin
                    dm_bus.addr = {st_ff.bank, cml_bus.rdata};
                end else begin
                    dm_bus.addr = {!st_ff.bank, cml_bus.rdata};
                end
                dm_rd = 1'b1;
                nxt_st.cmh_l = cmh_bus.rdata;
                nxt_st.cml_l = cml_bus.rdata;
                nxt_st.seq = tss_pkg::sq_st;
            end
            tss_pkg::sq_st: begin
                nxt_st.nxt_byte[st_ff.ps] = st_ff.cmh_l[`TSS_CMH_MSG]
                    ? st_ff.cml_l : dm_bus.rdata;
                nxt_st.nxt_oe[st_ff.ps] = st_ff.cmh_l[`TSS_CMH_OE];
                nxt_st.nxt_cb[st_ff.ps] = st_ff.cmh_l[`TSS_CMH_CSO];
                nxt_st.ps = st_ff.ps + 3'h1;
                nxt_st.seq = (st_ff.ps == 3'h7) ? tss_pkg::sq_idle
                    : tss_pkg::sq_cm;
            end
        endcase

        // queued input bytes take the data memory whenever it is free
        if (!dm_rd && fifo_out_valid) begin
            dm_bus.addr = fifo_out_data[16:8];
            dm_bus.wdata = fifo_out_data[7:0];
            dm_bus.we = 1'b1;
            fifo_pop = 1'b1;
        end
        // a full queue stalls the capture pusher, never drops a byte
        if (st_ff.push_act && fifo_in_ready) begin
            nxt_st.pidx = st_ff.pidx + 3'h1;
            nxt_st.push_act = st_ff.pidx != 3'h7;
        end

        // bit boundary: frame pulse restarts count and swaps bank
        if (bnd) begin
            nxt_st.cnt = cnt_n;
            if (fp_act) begin
                nxt_st.bank = !st_ff.bank;
            end
            if (!cnt_n[0]) begin
                if (bp == 3'h0) begin
                    // channel start: load prefetched bytes, fetch next
                    nxt_st.shout = st_ff.nxt_byte;
                    nxt_st.chan_oe = st_ff.nxt_oe;
                    nxt_st.cbits = st_ff.nxt_cb;
                    nxt_st.pf_req = 1'b1;
                    nxt_st.pch = cnt_n[8:4] + 5'h01;
                end
                for (int s = 0; s < 8; s++) begin
                    nxt_st.so[s] = nxt_st.shout[s][3'h7 - bp];
                end
                nxt_st.cso = nxt_st.cbits[bp];
            end
        end

        // three quarters into the bit: sample all input lines
        if (smp && st_ff.cnt[0]) begin
            for (int s = 0; s < 8; s++) begin
                nxt_st.shin[s] = {st_ff.shin[s][6:0], st_ff.ilv[s]};
            end
            if (st_ff.cnt[3:1] == 3'h7) begin
                nxt_st.hold = nxt_st.shin;
                nxt_st.hold_bank = st_ff.bank;
                nxt_st.hold_ch = st_ff.cnt[8:4];
                nxt_st.push_act = 1'b1;
                nxt_st.pidx = 3'h0;
            end
        end

        // global enable overrides the per-channel enables
        nxt_st.soe = {8{st_ff.mlv[`TSS_MS_ODE]}} & st_ff.chan_oe;
        nxt_st.ack_n = !nxt_st.ack;
    end

    // reset clears every register, which also floats every output that has an enable
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign serial_out_lines_out = st_ff.so;
    assign serial_out_lines_oe_out = st_ff.soe;
    assign ctrl_serial_out = st_ff.cso;
    assign host_data_out = st_ff.hdo;
    assign host_data_oe_out = st_ff.hoe;
    assign xfer_ack_n_out = st_ff.ack_n;
    assign xfer_ack_n_oe_out = st_ff.ack;

    a_reset_all_hiz: assert property (@(posedge mclk_in)
        !rst_n_in |=> serial_out_lines_oe_out == 8'h00
            && !host_data_oe_out && !xfer_ack_n_oe_out)
        else $error("outputs driven after reset");
    a_ode_all_hiz: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        !st_ff.mlv[`TSS_MS_ODE] |=> serial_out_lines_oe_out == 8'h00)
        else $error("serial output driven with drive enable low");
    a_chan_tri_off: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        st_ff.mlv[`TSS_MS_ODE] && !st_ff.chan_oe[0]
            |=> !serial_out_lines_oe_out[0])
        else $error("channel driven although disabled");
    a_ack_needs_acc: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        $rose(xfer_ack_n_oe_out) |-> $past(acc) && !xfer_ack_n_out)
        else $error("acknowledge without strobe and select");
    a_ack_holds: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        xfer_ack_n_oe_out && acc |=> xfer_ack_n_oe_out)
        else $error("acknowledge dropped during access");
    a_ack_release: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        xfer_ack_n_oe_out && !acc |=> !xfer_ack_n_oe_out && !host_data_oe_out)
        else $error("acknowledge not released");
    a_drive_on_read: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        host_data_oe_out |-> st_ff.hrd && xfer_ack_n_oe_out)
        else $error("data bus driven on a write");
    a_frame_cnt_clr: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        bnd && fp_act |=> st_ff.cnt == 9'h000 && st_ff.bank != $past(st_ff.bank))
        else $error("frame pulse did not restart the counter");
    a_prefetch_time: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        st_ff.seq == tss_pkg::sq_idle ##1 st_ff.seq == tss_pkg::sq_cm
            |-> ##24 st_ff.seq == tss_pkg::sq_idle)
        else $error("prefetch of eight streams not done in 24 cycles");
    a_msg_source: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        st_ff.seq == tss_pkg::sq_st && st_ff.cmh_l[`TSS_CMH_MSG]
            |=> st_ff.nxt_byte[$past(st_ff.ps)] == $past(st_ff.cml_l))
        else $error("message channel not sourced from connection low");
    a_ctrl_bit: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        bnd && !cnt_n[0] && bp != 3'h0
            |=> ctrl_serial_out == st_ff.cbits[$past(bp)])
        else $error("control serial bit mismatch");
endmodule : tss_switch

/* File: core/tss_cfg.svh */
// tss_cfg.svh: constants of the time-slot switch (field positions,
// reset values, timing figures).
// assumes: included by bare name from the switch design files.
`ifndef TSS_CFG_SVH
`define TSS_CFG_SVH

// clock figures
`define TSS_MCLK_KHZ 200000
`define TSS_SCLK_KHZ 4096
// minimum reset pulse the host must give, and its length in mclk cycles
`define TSS_RST_MIN_NS 100
`define TSS_RST_MIN_CYC ((`TSS_RST_MIN_NS * (`TSS_MCLK_KHZ / 1000) + 999) / 1000)

// positions inside the synchronised miscellaneous pin vector
`define TSS_MS_SCK 0
`define TSS_MS_FS 1
`define TSS_MS_ODE 2
`define TSS_MS_CSN 3
`define TSS_MS_DS 4

// per-channel control byte (connection memory high half)
`define TSS_CMH_OE 0
`define TSS_CMH_MSG 1
`define TSS_CMH_CONST 2
`define TSS_CMH_CSO 3

// host addressing: A5 low picks the control register
`define TSS_HA_MEM 5
`define TSS_CTRL_SEL_LSB 3
`define TSS_SEL_DM 2'h0
`define TSS_SEL_CML 2'h1
`define TSS_SEL_CMH 2'h2
`define TSS_CTRL_RST 8'h00

// frame pulse polarity learning: rising clock edges of unchanged level
`define TSS_RUN_MIN 5'h10

`endif

/* File: core/tss_pkg.sv */
// tss_pkg: types of the time-slot switch.
// assumes: compiled before every other switch file.
package tss_pkg;

    // sequencer of the single memory access engine
    typedef enum logic [2:0] {sq_idle, sq_cm, sq_dm, sq_st, sq_hrd} tss_seq_t;

    // complete state of the switch top
    typedef struct packed {
        logic [7:0] m1;
        logic [7:0] m2;
        logic [7:0] m3;
        logic [7:0] mlv;
        logic [7:0] i1;
        logic [7:0] i2;
        logic [7:0] i3;
        logic [7:0] ilv;
        logic fs_last;
        logic [4:0] run;
        logic idle_lvl;
        logic det;
        logic [8:0] cnt;
        logic bank;
        logic [7:0][7:0] shin;
        logic [7:0][7:0] hold;
        logic hold_bank;
        logic [4:0] hold_ch;
        logic push_act;
        logic [2:0] pidx;
        logic [7:0][7:0] shout;
        logic [7:0][7:0] nxt_byte;
        logic [7:0] nxt_oe;
        logic [7:0] nxt_cb;
        logic [7:0] chan_oe;
        logic [7:0] cbits;
        logic pf_req;
        logic [4:0] pch;
        tss_seq_t seq;
        logic [2:0] ps;
        logic [7:0] cmh_l;
        logic [7:0] cml_l;
        logic [7:0] ctrl;
        logic hrd;
        logic ack;
        logic ack_n;
        logic [7:0] hdo;
        logic hoe;
        logic [7:0] so;
        logic [7:0] soe;
        logic cso;
    } tss_st_t;

endpackage : tss_pkg

/* File: core/tss_mem_if.sv */
// tss_mem_if: one port of a switch memory, address in, read data out.
// assumes: read data appear one clock after the address.
`timescale 1ns/10ps
interface tss_mem_if #(parameter int AW = 8, parameter int DW = 8);
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic we;
    logic [DW-1:0] rdata;
    modport ctl (output addr, output wdata, output we, input rdata);
    modport mem (input addr, input wdata, input we, output rdata);
endinterface : tss_mem_if

/* File: core/tss_ram.sv */
// tss_ram: single port memory with registered read data.
// assumes: one access per clock; contents are not cleared by reset.
`timescale 1ns/10ps
module tss_ram #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic clk_in,
    tss_mem_if.mem bus_if
);
    logic [DW-1:0] mem_ff [0:(1 << AW) - 1];
    logic [DW-1:0] rd_ff;

    if (AW < 1 || DW < 1) begin : g_chk
        $error("tss_ram: bad geometry");
    end

    // write first into the array, read the old word out of a register
    always_ff @(posedge clk_in) begin
        if (bus_if.we) begin
            mem_ff[bus_if.addr] <= bus_if.wdata;
        end
        rd_ff <= mem_ff[bus_if.addr];
    end

    assign bus_if.rdata = rd_ff;
endmodule : tss_ram

/* File: core/tss_fifo.sv */
// tss_fifo: small first-in first-out queue, valid/ready on both sides.
// assumes: one clock, synchronous active-low reset.
`timescale 1ns/10ps
module tss_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } tss_fifo_st_t;

    tss_fifo_st_t st_ff;
    tss_fifo_st_t nxt_st;
    logic full;
    logic empty;

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("tss_fifo: depth must be a power of two, at least 2");
    end

    // wrap bit differs with equal index: full; pointers equal: empty
    assign full = (st_ff.wp[AW] != st_ff.rp[AW])
        && (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]);
    assign empty = (st_ff.wp == st_ff.rp);
    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = st_ff.mem[st_ff.rp[AW-1:0]];

    always_comb begin
        nxt_st = st_ff;
        if (in_valid_in && !full) begin
            nxt_st.mem[st_ff.wp[AW-1:0]] = in_data_in;
            nxt_st.wp = st_ff.wp + 1'b1;
        end
        if (out_ready_in && !empty) begin
            nxt_st.rp = st_ff.rp + 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    a_fifo_no_over: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        full && !out_ready_in |=> full && $stable(st_ff.wp))
        else $error("fifo accepted a word while full");
endmodule : tss_fifo

/* File: testbench/tss_bp_model.sv */
// tss_bp_model: backplane side; serial clock, frame pulse, input lines,
// and a record of the switch outputs over the last frame.
// assumes: 64 ns serial clock; frame pulse active low, or active high
// with gci_in set.
`timescale 1ns/10ps
module tss_bp_model (
    output logic sck_out,
    output logic fs_out,
    output logic [7:0] sin_out,
    input wire logic [7:0] so_in,
    input wire logic [7:0] soe_in,
    input wire logic cso_in,
    input wire logic gci_in
);
    logic [9:0] h = 10'h3F0;
    logic [9:0] p;
    logic [7:0] b;
    logic [7:0] so_q [256];
    logic [7:0] oe_q [256];
    logic cs_q [256];
    // four half periods a bit, 1024 a frame; line s channel c sends {s,c}
    initial begin
        sck_out = 1'b0;
        fs_out = 1'b1;
        sin_out = 8'h00;
        forever begin
            #32;
            h = h + 10'h001;
            // bits start on a falling edge, or a rising one for a high pulse
            p = h - {9'h000, gci_in};
            sck_out = h[0];
            fs_out = gci_in ^ !(p == 10'h3FF || p == 10'h000);
            for (int s = 0; s < 8; s++) begin
                b = {3'(s), p[9:5]};
                if (p[1:0] == 2'h0) sin_out[s] = b[3'h7 - p[4:2]];
            end
            // sample late in the bit, once the outputs have settled
            if (p[1:0] == 2'h3) begin
                so_q[p[9:2]] = so_in;
                oe_q[p[9:2]] = soe_in;
                cs_q[p[9:2]] = cso_in;
            end
        end
    end
endmodule : tss_bp_model

/* File: testbench/testbench.sv */
// testbench: host port accesses and serial output checks of the switch.
// assumes: design files and tss_bp_model compiled first.
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic out_drive_en = 1'b1;
    logic gci = 1'b0;
    logic [5:0] ad = 6'h00;
    logic ds = 1'b0;
    logic cs_n = 1'b1;
    logic rw = 1'b1;
    logic [7:0] wd = 8'h00;
    logic sck, fs, cso, hoe, ack_n, ack_oe;
    logic [7:0] sin, so, soe, hd, rd, msg, src, any;
    logic [2:0] s;
    logic [4:0] c, c1, c2;
    logic [31:0] rnd = 32'h9926B7E0;
    int err_count = 0;
    int n_tests = 0;
    always #2.5 clk = ~clk;
    tss_switch tss_switch_i (.mclk_in(clk), .rst_n_in(rst_n),
        .serial_clk_in(sck), .frame_sync_in(fs), .serial_in_lines_in(sin),
        .out_drive_en_in(out_drive_en), .host_addr_in(ad), .host_strobe_in(ds),
        .host_cs_n_in(cs_n), .host_rw_in(rw), .host_data_in(wd),
        .serial_out_lines_out(so), .serial_out_lines_oe_out(soe),
        .ctrl_serial_out(cso), .host_data_out(hd),
        .host_data_oe_out(hoe), .xfer_ack_n_out(ack_n),
        .xfer_ack_n_oe_out(ack_oe));
    tss_bp_model tss_bp_model_i (.sck_out(sck), .fs_out(fs),
        .sin_out(sin), .so_in(so), .soe_in(soe), .cso_in(cso),
        .gci_in(gci));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // a switched channel carries the byte its source line sends
    function automatic logic [7:0] in_byte(input logic [7:0] a);
        return {a[7:5], a[4:0]};
    endfunction : in_byte
    // one recorded channel byte of a line, data or drive enable
    function automatic logic [7:0] get(input logic e, input logic [2:0] l,
                                       input logic [4:0] ch);
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v[7-i] = e ? tss_bp_model_i.oe_q[{ch, 3'(i)}][l]
                       : tss_bp_model_i.so_q[{ch, 3'(i)}][l];
        end
        return v;
    endfunction : get
    task automatic chk(input logic [7:0] g, input logic [7:0] e,
                       input string m);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    // one strobed access; pins held until the acknowledge is seen
    task automatic acc(input logic r, input logic [5:0] a,
                       input logic [7:0] d);
        int n;
        @(posedge clk) #1;
        rw = r;
        ad = a;
        wd = d;
        ds = 1'b1;
        cs_n = 1'b0;
        for (n = 0; n < 60 && ack_oe !== 1'b1; n++) @(posedge clk) #1;
        rd = hd;
        chk({7'h0, ack_oe}, 8'h01, "ack");
        chk({7'h0, hoe}, {7'h0, r}, "bus dir");
        ds = 1'b0;
        cs_n = 1'b1;
        for (n = 0; n < 10 && ack_oe !== 1'b0; n++) @(posedge clk) #1;
        chk({7'h0, ack_oe}, 8'h00, "ack release");
    endtask : acc
    task automatic print_verdict();
        if (err_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    // watchdog sized for about twelve frames
    initial begin
        #400000;
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge clk);
        #1;
        chk(soe, 8'h00, "oe in reset");
        rst_n = 1'b1;
        acc(1'b1, 6'h00, 8'h00);
        chk(rd, 8'h00, "ctrl reset");
        rnd = lfsr(rnd);
        acc(1'b0, 6'h01, rnd[7:0]);
        acc(1'b1, 6'h1F, 8'h00);
        chk(rd, rnd[7:0], "ctrl");
        @(posedge clk) #1;
        ds = 1'b1;
        rw = 1'b0;
        repeat (20) @(posedge clk) #1;
        chk({7'h0, ack_oe}, 8'h00, "no select");
        ds = 1'b0;
        acc(1'b1, 6'h00, 8'h00);
        chk(rd, rnd[7:0], "ctrl kept");
        rnd = lfsr(rnd);
        s = rnd[2:0];
        c = rnd[7:3];
        msg = rnd[15:8];
        src = rnd[23:16];
        c1 = c + 5'h01;
        c2 = c + 5'h02;
        // write zero to every address, stream by stream, with the data memory selected, so nothing is stored
        for (int i = 0; i < 256; i++) begin
            if (i[4:0] == 5'h00) acc(1'b0, 6'h00, {5'h10, 3'(i >> 5)});
            acc(1'b0, {1'b1, 5'(i)}, 8'h00);
        end
        acc(1'b0, 6'h00, {3'h0, 2'h2, s});
        acc(1'b0, {1'b1, c}, 8'h0B);
        acc(1'b0, {1'b1, c1}, {5'h00, rnd[24], 2'h1});
        acc(1'b0, 6'h00, {3'h0, 2'h1, s});
        acc(1'b0, {1'b1, c}, msg);
        acc(1'b0, {1'b1, c1}, src);
        // pass 0: low pulse; pass 1: high pulse and the other delay mode
        for (int g = 0; g < 2; g++) begin
            acc(1'b0, 6'h00, {3'h0, 2'h2, s});
            acc(1'b0, {1'b1, c1}, {5'h00, rnd[24] ^ g[0], 2'h1});
            gci = g[0];
            // polarity is relearned, then two whole frames fill both banks
            repeat ((3 + g) * 6600) @(posedge clk) #1;
            chk(get(1'b0, s, c), msg, "message");
            chk(get(1'b0, s, c1), in_byte(src), "switched");
            chk(get(1'b1, s, c), 8'hFF, "oe on");
            chk(get(1'b1, s, c2), 8'h00, "chan off");
            chk({7'h0, tss_bp_model_i.cs_q[{c, s}]}, 8'h01, "cbit");
            chk({7'h0, tss_bp_model_i.cs_q[{c1, s}]}, 8'h00, "cb0");
        end
        acc(1'b1, {1'b1, c}, 8'h00);
        chk(rd, 8'h0B, "cmh read");
        acc(1'b0, 6'h00, {3'h0, 2'h0, s});
        acc(1'b1, {1'b1, c}, 8'h00);
        chk(rd, {s, c}, "dm read");
        out_drive_en = 1'b0;
        repeat (2 * 6600) @(posedge clk);
        any = 8'h00;
        for (int i = 0; i < 256; i++) any |= tss_bp_model_i.oe_q[i];
        chk(any, 8'h00, "drive off");
        print_verdict();
    end
endmodule : testbench
